// >>> src/sub_borrow_pkg.sv
package sub_borrow_pkg;
    localparam int DATA_W     = 8;
    localparam int NIBBLE_W   = 4;
    localparam int MSB        = DATA_W - 1;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic       CARRY_RST = 1'b0;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_TO_ACC,
        OP_TO_MEM
    } sub_op_t;

    typedef struct packed {
        logic signed_range_flag;
        logic zero_flag;
        logic half_borrow_flag;
        logic carry_flag;
        logic signed_compare_flag;
        logic compare_null_flag;
    } flags_t;

    typedef struct packed {
        logic [7:0] working_register;
        flags_t     flags;
        logic       mem_we;
        logic [7:0] mem_wdata;
        logic       done;
    } state_t;
endpackage : sub_borrow_pkg

// >>> src/sub_borrow_ops.sv
// Contract
// - result is acc minus mem minus not-carry
// - accumulator variant writes acc, not memory
// - memory variant writes result back to memory
// - carry cleared on borrow, else set
// - update ov, z, ac, c, sc, cz flags
`timescale 1ns/1ps
module sub_borrow_ops (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   sub_borrow_to_accumulator,
    input  wire logic                   sub_borrow_to_memory,
    input  wire logic [7:0]             mem_rdata,
    output logic [7:0]                  working_register,
    output sub_borrow_pkg::flags_t      flags,
    output logic                        mem_we,
    output logic [7:0]                  mem_wdata,
    output logic                        done
);
    localparam int W = sub_borrow_pkg::DATA_W;
    localparam int H = sub_borrow_pkg::NIBBLE_W;
    localparam int M = sub_borrow_pkg::MSB;

    // registered state and its next value
    sub_borrow_pkg::state_t  state_reg;
    sub_borrow_pkg::state_t  state_next;

    // decoded operation
    sub_borrow_pkg::sub_op_t op;

    // subtractor operands, borrow ripple and zero chain
    logic [W-1:0]            minuend;
    logic [W-1:0]            subtrahend;
    logic                    borrow_in;
    wire  [W:0]              borrow_chain;
    wire  [W:0]              zero_chain;
    wire  [W-1:0]            res;
    logic                    borrow_out;
    logic                    half_borrow;

    // flag terms
    logic                    res_neg;
    logic                    res_zero;
    logic                    ov_term;
    logic                    zero_term;
    logic                    half_term;
    logic                    carry_term;
    logic                    sc_term;
    logic                    cz_term;
    sub_borrow_pkg::flags_t  flags_calc;

    // strobe decode, accumulator variant wins
    always_comb begin
        op = sub_borrow_pkg::OP_NONE;
        if (sub_borrow_to_accumulator) begin
            op = sub_borrow_pkg::OP_TO_ACC;
        end else if (sub_borrow_to_memory) begin
            op = sub_borrow_pkg::OP_TO_MEM;
        end
    end

    always_comb begin
        minuend    = state_reg.working_register;
        subtrahend = mem_rdata;
        borrow_in  = ~state_reg.flags.carry_flag;
    end

    assign borrow_chain[0] = borrow_in;
    assign zero_chain[0]   = 1'b1;

    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < W; bit_idx = bit_idx + 1) begin : g_sub_bit
            // one bit of the borrow ripple
            assign res[bit_idx]            = minuend[bit_idx] ^ subtrahend[bit_idx] ^ borrow_chain[bit_idx];
            assign borrow_chain[bit_idx+1] = (~minuend[bit_idx] & subtrahend[bit_idx])
                                           | (~(minuend[bit_idx] ^ subtrahend[bit_idx]) & borrow_chain[bit_idx]);
            assign zero_chain[bit_idx+1]   = zero_chain[bit_idx] & ~res[bit_idx];
        end
    endgenerate

    // borrow out of the top bit and of the low nibble
    always_comb begin
        borrow_out  = borrow_chain[W];
        half_borrow = borrow_chain[H];
    end

    // result sign
    always_comb begin
        res_neg = res[M];
    end

    // result zero
    always_comb begin
        res_zero = zero_chain[W];
    end

    always_comb begin
        if ((minuend[M] ^ subtrahend[M]) & (minuend[M] ^ res_neg)) begin
            ov_term = 1'b1;
        end else begin
            ov_term = 1'b0;
        end
    end

    always_comb begin
        if (res_zero) begin
            zero_term = 1'b1;
        end else begin
            zero_term = 1'b0;
        end
    end

    always_comb begin
        if (half_borrow) begin
            half_term = 1'b0;
        end else begin
            half_term = 1'b1;
        end
    end

    // carry clear on borrow, else set
    always_comb begin
        if (borrow_out) begin
            carry_term = 1'b0;
        end else begin
            carry_term = 1'b1;
        end
    end

    // signed compare, set when no signed borrow
    always_comb begin
        if (ov_term ^ res_neg) begin
            sc_term = 1'b0;
        end else begin
            sc_term = 1'b1;
        end
    end

    // compare zero chained with previous zero
    always_comb begin
        if (res_zero && state_reg.flags.zero_flag) begin
            cz_term = 1'b1;
        end else begin
            cz_term = 1'b0;
        end
    end

    always_comb begin
        flags_calc.signed_range_flag   = ov_term;
        flags_calc.zero_flag           = zero_term;
        flags_calc.half_borrow_flag    = half_term;
        flags_calc.carry_flag          = carry_term;
        flags_calc.signed_compare_flag = sc_term;
        flags_calc.compare_null_flag   = cz_term;
    end

    // next state
    always_comb begin
        state_next        = state_reg;
        state_next.mem_we = 1'b0;
        state_next.done   = 1'b0;
        case (op)
            sub_borrow_pkg::OP_TO_ACC: begin
                state_next.flags            = flags_calc;
                state_next.done             = 1'b1;
                state_next.working_register = res;
                state_next.mem_we           = 1'b0;
                state_next.mem_wdata        = state_reg.mem_wdata;
            end

            sub_borrow_pkg::OP_TO_MEM: begin
                state_next.flags            = flags_calc;
                state_next.done             = 1'b1;
                state_next.mem_we           = 1'b1;
                state_next.mem_wdata        = res;
                state_next.working_register = state_reg.working_register;
            end

            default: begin
                state_next.flags            = state_reg.flags;
                state_next.working_register = state_reg.working_register;
                state_next.mem_wdata        = state_reg.mem_wdata;
            end
        endcase
    end

    // synchronous reset to idle values
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg                           <= '0;
            state_reg.working_register          <= sub_borrow_pkg::ACC_RST;
            state_reg.flags.carry_flag          <= sub_borrow_pkg::CARRY_RST;
            state_reg.flags.signed_range_flag   <= 1'b0;
            state_reg.flags.zero_flag           <= 1'b0;
            state_reg.flags.half_borrow_flag    <= 1'b0;
            state_reg.flags.signed_compare_flag <= 1'b0;
            state_reg.flags.compare_null_flag   <= 1'b0;
            state_reg.mem_we                    <= 1'b0;
            state_reg.mem_wdata                 <= 8'h00;
            state_reg.done                      <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign working_register = state_reg.working_register;
    assign flags            = state_reg.flags;
    assign mem_we           = state_reg.mem_we;
    assign mem_wdata        = state_reg.mem_wdata;
    assign done             = state_reg.done;
endmodule : sub_borrow_ops

// >>> tb/sub_borrow_ops_checker.sv
`timescale 1ns/1ps
module sub_borrow_ops_checker (
    input logic                   core_clk,
    input logic                   rst,
    input logic                   sub_borrow_to_accumulator,
    input logic                   sub_borrow_to_memory,
    input logic [7:0]             mem_rdata,
    input logic [7:0]             working_register,
    input sub_borrow_pkg::flags_t flags,
    input logic                   mem_we,
    input logic [7:0]             mem_wdata,
    input logic                   done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire ta = sub_borrow_to_accumulator;
    wire tm = sub_borrow_to_memory & !ta;
    wire nc = !flags.carry_flag;
    wire [8:0] d = {1'b0, working_register} - {1'b0, mem_rdata} - {8'h00, nc};
    wire [4:0] n = {1'b0, working_register[3:0]} - {1'b0, mem_rdata[3:0]} - {4'h0, nc};
    wire [7:0] r = d[7:0];
    wire b = d[8];
    wire h = n[4];
    wire zr = (r == 8'h00);
    a_acc_result: assert property (ta |=> done && !mem_we && working_register == $past(r))
        else $error("acc result");
    a_compare_null: assert property (ta | tm |=> flags.compare_null_flag == ($past(zr) && $past(flags.zero_flag)))
        else $error("compare null");
    a_idle_quiet: assert property (!(ta | tm) |=> !done && !mem_we) else $error("idle quiet");
    a_mem_result: assert property (tm |=> done && mem_we && mem_wdata == $past(r)) else $error("mem result");
    a_carry_borrow: assert property (ta | tm |=> flags.carry_flag != $past(b)) else $error("carry");
    a_half_borrow: assert property (ta | tm |=> flags.half_borrow_flag != $past(h)) else $error("half");
    a_zero_flag: assert property (ta | tm |=> flags.zero_flag == ($past(r) == 8'h00)) else $error("zero");
    a_acc_kept: assert property (tm |=> $stable(working_register)) else $error("acc kept");
endmodule : sub_borrow_ops_checker
bind sub_borrow_ops sub_borrow_ops_checker i_sub_borrow_ops_checker (.core_clk, .rst, .sub_borrow_to_accumulator,
    .sub_borrow_to_memory, .mem_rdata, .working_register, .flags, .mem_we, .mem_wdata, .done);

// >>> tb/tb_sub_borrow_ops.sv
`timescale 1ns/1ps
module tb_sub_borrow_ops;
    logic                   core_clk = 1'b0, rst = 1'b1, ta = 1'b0, tm = 1'b0, c_m = 1'b0, z_m = 1'b0, mem_we, done;
    logic                   v_m, s_m, h_m;
    logic [7:0]             mem_rdata = 8'h00, a_m = 8'h00, w_m = 8'h00, r_m, working_register, mem_wdata;
    logic [22:0]            q[$];
    sub_borrow_pkg::flags_t flags;
    int                     bad_count = 0, total_checks = 0, seed = 32'hf949, ures, sres, hres;
    always #4 core_clk = ~core_clk;
    sub_borrow_ops i_sub_borrow_ops (.core_clk, .rst, .sub_borrow_to_accumulator(ta), .sub_borrow_to_memory(tm),
        .mem_rdata, .working_register, .flags, .mem_we, .mem_wdata, .done);
    task automatic check(input logic [22:0] e, input logic [22:0] s);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value result exp %h got %h", e, s);
        end
    endtask : check
    task automatic finish_test();
        if (bad_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    always @(negedge core_clk) if (done === 1'b1) begin
        check(q.size() ? q.pop_front() : 23'hx, {working_register, flags, mem_we, mem_wdata});
    end
    initial begin
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        for (int i = 0; i < 600; i++) begin
            {ta, tm} = 2'($random(seed));
            mem_rdata = 8'($random(seed));
            if (i % 8 < 2) mem_rdata = 8'(int'(a_m) - int'(!c_m));
            if (ta | tm) begin
                ures = int'(a_m) - int'(mem_rdata) - int'(!c_m);
                sres = int'($signed(a_m)) - int'($signed(mem_rdata)) - int'(!c_m);
                hres = int'(a_m[3:0]) - int'(mem_rdata[3:0]) - int'(!c_m);
                r_m = 8'(ures);
                v_m = (sres < -128) || (sres > 127);
                s_m = (sres >= 0);
                h_m = (hres >= 0);
                c_m = (ures >= 0);
                if (ta) a_m = r_m;
                else w_m = r_m;
                q.push_back({a_m, v_m, r_m == 8'h00, h_m, c_m, s_m, (r_m == 8'h00) && z_m, !ta, w_m});
                z_m = (r_m == 8'h00);
            end
            @(negedge core_clk);
        end
        {ta, tm} = 2'h0;
        repeat (2) @(negedge core_clk);
        if (q.size() != 0) bad_count++;
        finish_test();
    end
endmodule : tb_sub_borrow_ops
